// ---- logic/sewake_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sewake_params.svh"
module sewake_ctrl #(
  parameter int NUM_SRC = `SEWAKE_NUM_SRC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic sleep_exec_i,
  input wire logic global_interrupt_enable_i,
  input wire logic [NUM_SRC-1:0] int_enable_i,
  input wire logic [NUM_SRC-1:0] int_flag_i,
  input wire logic status_flags_clear_i,
  output logic sleeping_o,
  output logic sleep_nop_o,
  output logic wake_o,
  output logic wake_vector_o,
  output logic watchdog_timer_clear_o,
  output logic watchdog_prescaler_clear_o,
  output logic timeout_status_flag_o,
  output logic powerdown_status_flag_o,
  output var sewake_pkg::sewake_state_t state_o
);
  import sewake_pkg::*;

  sewake_state_t state;
  sewake_state_t next_state;
  logic [NUM_SRC-1:0] src_pend;
  logic pending;
  logic sleep_take;
  logic sleep_as_nop;
  logic sleep_complete;
  logic wake_hit;
  logic next_nop;
  logic next_wdt_clear;
  logic next_presc_clear;
  logic next_to;
  logic next_pd;
  logic next_wake;
  logic next_wake_vector;

  // Per-source qualification
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_src
      assign src_pend[gi] = int_enable_i[gi] & int_flag_i[gi];
    end
  endgenerate

  // Global enable plays no part in pending
  assign pending = |src_pend;

  // Request only counts while running; pulses in other states are dropped
  assign sleep_take = sleep_exec_i && (state == SEWAKE_RUN);

  // Flag already pending with global enable off: no-op
  assign sleep_as_nop = sleep_take && pending && !global_interrupt_enable_i;

  // ENTER is the single cycle in which the sleep completes
  assign sleep_complete = (state == SEWAKE_ENTER);

  // Wake from ENTER or ASLEEP on any enabled flag
  assign wake_hit = (state != SEWAKE_RUN) && pending;

  always_comb begin
    next_state = state;
    unique case (state)
      SEWAKE_RUN: begin
        // Pending before the request keeps the core running only with global enable off (no-op)
        if (sleep_take && !sleep_as_nop) begin
          next_state = SEWAKE_ENTER;
        end
      end
      SEWAKE_ENTER: begin
        // Sleep always completes once entered; late flag wakes next
        if (pending) begin
          next_state = SEWAKE_RUN;
        end else begin
          next_state = SEWAKE_ASLEEP;
        end
      end
      SEWAKE_ASLEEP: begin
        // Enable alone qualifies wake
        if (pending) begin
          next_state = SEWAKE_RUN;
        end
      end
      default: begin
        // Unused code falls back to running rather than locking up
        next_state = SEWAKE_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= SEWAKE_RUN;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // No-op report pulse
  assign next_nop = sleep_as_nop;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sleep_nop_o <= 1'h0;
    end else if (ce_i) begin
      sleep_nop_o <= next_nop;
    end
  end

  // Clears only on completion, never on the no-op path
  assign next_wdt_clear = sleep_complete;
  assign next_presc_clear = sleep_complete;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      watchdog_timer_clear_o <= 1'h0;
    end else if (ce_i) begin
      watchdog_timer_clear_o <= next_wdt_clear;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      watchdog_prescaler_clear_o <= 1'h0;
    end else if (ce_i) begin
      watchdog_prescaler_clear_o <= next_presc_clear;
    end
  end

  // Completion wins over a reload in the same cycle, so a sleep is never hidden
  always_comb begin
    next_to = timeout_status_flag_o;
    next_pd = powerdown_status_flag_o;
    if (sleep_complete) begin
      next_to = 1'h1;
      next_pd = 1'h0;
    end else if (status_flags_clear_i) begin
      next_to = `SEWAKE_TO_RESET;
      next_pd = `SEWAKE_PD_RESET;
    end
    // No-op path leaves both flags untouched
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timeout_status_flag_o <= `SEWAKE_TO_RESET;
    end else if (ce_i) begin
      timeout_status_flag_o <= next_to;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      powerdown_status_flag_o <= `SEWAKE_PD_RESET;
    end else if (ce_i) begin
      powerdown_status_flag_o <= next_pd;
    end
  end

  // Wake pulse; resume at the next instruction
  assign next_wake = wake_hit;

  // Vector only with global enable set, else plain resume
  assign next_wake_vector = wake_hit && global_interrupt_enable_i;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_o <= 1'h0;
    end else if (ce_i) begin
      wake_o <= next_wake;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_vector_o <= 1'h0;
    end else if (ce_i) begin
      wake_vector_o <= next_wake_vector;
    end
  end

  // Level straight from the state register, no extra latency
  assign sleeping_o = (state == SEWAKE_ASLEEP);

  assign state_o = state;
endmodule
`default_nettype wire

// ---- logic/sewake_params.svh ----
`ifndef SEWAKE_PARAMS_SVH
`define SEWAKE_PARAMS_SVH
`define SEWAKE_NUM_SRC 8
`define SEWAKE_TO_RESET 1'h1
`define SEWAKE_PD_RESET 1'h1
`endif

// ---- logic/sewake_pkg.sv ----
package sewake_pkg;
  typedef enum logic [1:0] {
    SEWAKE_RUN,
    SEWAKE_ENTER,
    SEWAKE_ASLEEP
  } sewake_state_t;
endpackage

// ---- test/sewake_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module sewake_sva import sewake_pkg::*; #(
  parameter int NUM_SRC = 8
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic sleep_exec_i,
  input wire logic global_interrupt_enable_i,
  input wire logic [NUM_SRC-1:0] int_enable_i,
  input wire logic [NUM_SRC-1:0] int_flag_i,
  input wire logic sleeping_o,
  input wire logic sleep_nop_o,
  input wire logic wake_o,
  input wire logic wake_vector_o,
  input wire logic watchdog_timer_clear_o,
  input wire logic watchdog_prescaler_clear_o,
  input wire logic timeout_status_flag_o,
  input wire logic powerdown_status_flag_o,
  input wire sewake_state_t state_o
);
  wire p = |(int_enable_i & int_flag_i);
  wire go = ce_i && sleep_exec_i && state_o == SEWAKE_RUN;
  wire n = go && p && !global_interrupt_enable_i;
  wire en = ce_i && state_o == SEWAKE_ENTER;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  a_nop_taken: assert property (n |=> sleep_nop_o) else $error("nop");
  a_nop_quiet: assert property (n |=> !watchdog_timer_clear_o) else $error("wdt");
  a_nop_presc: assert property (n |=> !watchdog_prescaler_clear_o) else $error("psc");
  a_nop_flags: assert property (n |=> $stable(powerdown_status_flag_o))
    else $error("pd");
  a_nop_timeout: assert property (n |=> $stable(timeout_status_flag_o))
    else $error("to");
  a_presc_clear: assert property (en |=> watchdog_prescaler_clear_o) else $error("pclr");
  a_sleep_level: assert property (en && !p |=> sleeping_o) else $error("lvl");
  a_ce_freeze: assert property (!ce_i |=> $stable(state_o) && $stable(powerdown_status_flag_o)
    && $stable(timeout_status_flag_o)) else $error("frz");
  a_sleep_enter: assert property (go && !n |=> state_o == SEWAKE_ENTER)
    else $error("st");
  a_done_clear: assert property (en |=> watchdog_timer_clear_o) else $error("clr");
  a_done_flags: assert property (en |=> timeout_status_flag_o
    && !powerdown_status_flag_o) else $error("fl");
  a_wake_now: assert property (en && p |=> wake_o) else $error("wk");
  a_asleep_wake: assert property (ce_i && p && state_o == SEWAKE_ASLEEP |=> wake_o)
    else $error("asleep");
  a_wake_vector: assert property (wake_o |->
    wake_vector_o == $past(global_interrupt_enable_i)) else $error("vec");
  c_nop: cover property (sleep_nop_o);
  c_vec: cover property (wake_o && wake_vector_o);
  c_asleep: cover property (state_o == SEWAKE_ASLEEP ##1 wake_o);
endmodule
bind sewake_ctrl sewake_sva #(.NUM_SRC(NUM_SRC)) u_sva (.*);
`default_nettype wire

// ---- test/test_sleep_entry_interrupt_wake.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_sleep_entry_interrupt_wake;
  logic mclk_i = 0, rstn_i = 0, ce_i = 1, sleep_exec_i = 0, status_flags_clear_i = 0;
  logic global_interrupt_enable_i = 0, sleep_nop_o, wake_o, wake_vector_o;
  logic powerdown_status_flag_o;
  logic [7:0] int_enable_i = 0, int_flag_i = 0;
  logic [2:0] e, q[$];
  logic [15:0] r = 16'hC2E0;
  int err_count = 0, n_checks = 0, i, k;
  always #4 mclk_i = ~mclk_i;
  sewake_ctrl DUT (.*, .sleeping_o(), .watchdog_timer_clear_o(),
    .watchdog_prescaler_clear_o(), .timeout_status_flag_o(), .state_o());
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) if (sleep_nop_o === 1'b1 || wake_o === 1'b1) begin
    e = q.size() ? q.pop_front() : 3'h7;
    n_checks++;
    if ({wake_o, wake_vector_o, powerdown_status_flag_o} !== e) begin
      err_count++;
      $display("unexpected %0t result", $time);
    end
  end
  initial begin
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1;
    for (i = 0; i < 200; i++) begin
      r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
      k = r[2:0];
      @(posedge mclk_i);
      // Unmatched enable and flag bits must not count as pending
      int_enable_i <= r[15:8] | 8'h1 << k;
      int_flag_i <= ~r[15:8] & ~(8'h1 << k) | {7'h0, r[3]} << k;
      global_interrupt_enable_i <= r[4];
      status_flags_clear_i <= 1;
      q.push_back(r[3] && !r[4] ? 3'h1 : {1'b1, r[4], 1'b0});
      @(posedge mclk_i);
      status_flags_clear_i <= 0;
      sleep_exec_i <= 1;
      @(posedge mclk_i);
      sleep_exec_i <= 0;
      // Random delay lands the flag in ENTER or ASLEEP
      repeat (r[6:5]) @(posedge mclk_i);
      int_flag_i[k] <= 1'b1;
      for (k = 0; k < 20 && q.size() > 0; k++) @(posedge mclk_i);
      if (q.size() > 0) begin
        err_count++;
        print_verdict;
      end
      // Frozen cycle: a reload request must not reach the flags
      ce_i <= 1'b0;
      status_flags_clear_i <= 1'b1;
      @(posedge mclk_i);
      ce_i <= 1'b1;
      status_flags_clear_i <= 1'b0;
    end
    print_verdict;
  end
endmodule
`default_nettype wire
